// File: scc_defs.svh
// Constants of the command and status core
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
// APB register offsets
`define SCC_OFF_CMD       12'h000
`define SCC_OFF_STAT      12'h004
`define SCC_OFF_PAT       12'h008
`define SCC_OFF_ESR       12'h00c
`define SCC_OFF_ESE       12'h010
`define SCC_OFF_OPER      12'h014
`define SCC_OFF_FILT      12'h018
`define SCC_OFF_IRQ_ST    12'h01c
`define SCC_OFF_IRQ_MASK  12'h020
`define SCC_OFF_ERRQ      12'h024
// Event status bit positions
`define SCC_BIT_OPC       0
`define SCC_BIT_EXE       4
`define SCC_BIT_CME       5
`define SCC_BIT_PON       7
// Virgin enable values
`define SCC_ESE_VIRGIN    8'ha0
`define SCC_ESE_VIRGIN_X  8'hb0
`define SCC_FAIL_VIRGIN   8'hff
`define SCC_FILT_VIRGIN   16'hffff
// Text characters
`define SCC_CH_COLON      8'h3a
`define SCC_CH_SEMI       8'h3b
`define SCC_CH_SPACE      8'h20
`define SCC_CH_QUERY      8'h3f
`define SCC_CH_LF         8'h0a
`define SCC_CH_STAR       8'h2a
`define SCC_CH_BAR        8'h7c
// Keyword limits
`define SCC_KW_MAX        12
`define SCC_KW_SHORT      4
`endif

// File: scc_pkg.sv
// Types of the command and status core
package scc_pkg;
  typedef enum logic [2:0] {PAT_PRBS, PAT_ZSUB, PAT_MDEN, PAT_UPAT, PAT_NONE} scc_pat_type;
  typedef enum logic [3:0] {KW_NONE, KW_SOUR, KW_PATT, KW_SEL, KW_GATE, KW_EYE, KW_TCEN, KW_ACEN,
                            KW_ELOC, KW_WAI, KW_IDN, KW_OPC, KW_CLS, KW_BAD} scc_kw_type;
  typedef enum logic [2:0] {ST_IDLE, ST_KEY, ST_PARM, ST_WAIT, ST_EXEC, ST_REPLY} scc_state_type;
endpackage

// File: scc_core.sv
// Command interpreter and status core with APB register access
`timescale 1ns/1ps
`include "scc_defs.svh"

module scc_core #(
  parameter int KW_MAX = `SCC_KW_MAX
) (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // Nonvolatile state
  input  wire logic        i_nv_valid,
  input  wire logic [7:0]  i_nv_ese,
  input  wire logic [7:0]  i_nv_fail_en,
  input  wire logic [15:0] i_nv_filt,
  output logic             o_nv_write,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Instrument functions
  output logic [3:0]       o_start,
  input  wire logic [3:0]  i_done,
  output logic [2:0]       o_pat_type,
  output logic [7:0]       o_pat_index,
  output logic             o_pat_load,
  input  wire logic        i_seq_busy,
  input  wire logic [7:0]  i_fail,
  input  wire logic [7:0]  i_oper_cond,
  // Service request
  output logic             o_irq,
  output logic             o_srq
);
  if (KW_MAX < `SCC_KW_SHORT || KW_MAX > 16) $error("KW_MAX out of range");

  typedef struct packed {
    scc_pkg::scc_state_type st;
    logic [31:0] rdata;
    logic [7:0]  ch;
    logic        ch_full;
    logic [4:0]  kw_len;
    logic [31:0] kw_hash;
    logic        kw_query;
    scc_pkg::scc_kw_type path;
    scc_pkg::scc_kw_type leaf;
    logic [2:0]  ptype;
    logic [7:0]  pidx;
    logic        pseen;
    logic [2:0]  pat_type;
    logic [7:0]  pat_idx;
    logic        pat_load;
    logic [3:0]  pend;
    logic [3:0]  start;
    logic [7:0]  esr;
    logic [7:0]  ese;
    logic [7:0]  fail_en;
    logic [15:0] filt;
    logic [7:0]  oper_ev;
    logic [7:0]  oper_q;
    logic [2:0]  oper_sel;
    logic [3:0]  irq_st;
    logic [3:0]  irq_mask;
    logic [3:0]  errq_cnt;
    logic [31:0] reply;
    logic        reply_v;
    logic        boot;
    logic        nv_wr;
  } scc_state_s_type;

  scc_state_s_type r_reg;
  scc_state_s_type r_next;

  // Case fold and keyword hash over uppercase letters
  function automatic logic [7:0] upc(input logic [7:0] c);
    upc = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction

  function automatic logic [31:0] hadd(input logic [31:0] h, input logic [7:0] c, input logic [4:0] n);
    hadd = (n < 5'(`SCC_KW_SHORT)) ? {h[23:0], upc(c)} : h;
  endfunction

  // Shortform prefix decides keyword, longform tail only counted against KW_MAX
  function automatic scc_pkg::scc_kw_type kw_dec(input logic [31:0] h, input logic [4:0] n);
    if (n > 5'(KW_MAX))
      kw_dec = scc_pkg::KW_BAD;
    else if (n == 5'd3 && h[23:0] == "EYE") kw_dec = scc_pkg::KW_EYE;
    else if (n == 5'd3 && h[23:0] == "SEL") kw_dec = scc_pkg::KW_SEL;
    else if (n == 5'd3 && h[23:0] == "WAI") kw_dec = scc_pkg::KW_WAI;
    else if (n == 5'd3 && h[23:0] == "IDN") kw_dec = scc_pkg::KW_IDN;
    else if (n == 5'd3 && h[23:0] == "OPC") kw_dec = scc_pkg::KW_OPC;
    else if (n == 5'd3 && h[23:0] == "CLS") kw_dec = scc_pkg::KW_CLS;
    else if (n >= 5'd4)
      case (h)
        "SOUR":  kw_dec = scc_pkg::KW_SOUR;
        "PATT":  kw_dec = scc_pkg::KW_PATT;
        "SELE":  kw_dec = scc_pkg::KW_SEL;
        "GATE":  kw_dec = scc_pkg::KW_GATE;
        "TCEN":  kw_dec = scc_pkg::KW_TCEN;
        "ACEN":  kw_dec = scc_pkg::KW_ACEN;
        "ELOC":  kw_dec = scc_pkg::KW_ELOC;
        default: kw_dec = scc_pkg::KW_BAD;
      endcase
    else
      kw_dec = scc_pkg::KW_BAD;
  endfunction

  function automatic logic [2:0] pat_dec(input logic [31:0] h);
    case (h)
      "PRBS":  pat_dec = 3'(scc_pkg::PAT_PRBS);
      "ZSUB":  pat_dec = 3'(scc_pkg::PAT_ZSUB);
      "MDEN":  pat_dec = 3'(scc_pkg::PAT_MDEN);
      "UPAT":  pat_dec = 3'(scc_pkg::PAT_UPAT);
      default: pat_dec = 3'(scc_pkg::PAT_NONE);
    endcase
  endfunction

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= 8'h30 && c <= 8'h39);
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic [7:0] c;
  logic term;
  scc_pkg::scc_kw_type k;
  logic [7:0] oper_rise;
  logic [7:0] oper_fall;
  logic [3:0] ev;
  logic [7:0] esr_set;

  assign wr_acc = i_psel & i_penable & i_pwrite;
  assign rd_acc = i_psel & i_penable & ~i_pwrite;
  assign c      = upc(r_reg.ch);
  assign term   = (c == `SCC_CH_SEMI) || (c == `SCC_CH_LF);

  always_comb
  begin
    r_next          = r_reg;
    r_next.start    = 4'h0;
    r_next.pat_load = 1'b0;
    r_next.nv_wr    = 1'b0;
    k               = kw_dec(r_reg.kw_hash, r_reg.kw_len);
    ev              = 4'h0;
    esr_set         = 8'h00;
    // -----------------------------
    // Power-up initialisation
    // -----------------------------
    if (r_reg.boot)
    begin
      r_next.boot    = 1'b0;
      r_next.esr     = 8'h80;
      if (i_nv_valid)
      begin
        r_next.ese     = i_nv_ese;
        r_next.fail_en = i_nv_fail_en;
        r_next.filt    = i_nv_filt;
      end
      else
      begin
        r_next.ese     = `SCC_ESE_VIRGIN_X;
        r_next.fail_en = `SCC_FAIL_VIRGIN;
        r_next.filt    = `SCC_FILT_VIRGIN;
        r_next.nv_wr   = 1'b1;
      end
    end
    // -----------------------------
    // Overlapped completion
    // -----------------------------
    if ((r_reg.pend & i_done) != 4'h0)
      esr_set[`SCC_BIT_OPC] = 1'b1;
    r_next.pend = r_reg.pend & ~i_done;
    // -----------------------------
    // Operation status edges
    // -----------------------------
    r_next.oper_q = i_oper_cond;
    oper_rise = i_oper_cond & ~r_reg.oper_q & r_reg.filt[7:0];
    oper_fall = ~i_oper_cond & r_reg.oper_q & r_reg.filt[15:8];
    r_next.oper_ev = r_reg.oper_ev | oper_rise | oper_fall;
    // -----------------------------
    // Parser
    // -----------------------------
    case (r_reg.st)
      scc_pkg::ST_IDLE:
      begin
        if (r_reg.ch_full)
        begin
          r_next.ch_full = 1'b0;
          if (c != `SCC_CH_SPACE && c != `SCC_CH_STAR && !term && c != `SCC_CH_COLON)
          begin
            r_next.kw_len  = 5'd1;
            r_next.kw_hash = {24'h0, c};
            r_next.st      = scc_pkg::ST_KEY;
          end
          else if (term)
            r_next.path = scc_pkg::KW_NONE;
        end
      end
      scc_pkg::ST_KEY:
      begin
        if (r_reg.ch_full)
        begin
          r_next.ch_full = 1'b0;
          if (c == `SCC_CH_COLON)
          begin
            r_next.path   = k;
            r_next.kw_len = 5'd0;
            r_next.kw_hash = 32'h0;
            if (k == scc_pkg::KW_BAD)
              ev[0] = 1'b1;
          end
          else if (c == `SCC_CH_QUERY)
            r_next.kw_query = 1'b1;
          else if (c == `SCC_CH_SPACE || term)
          begin
            // Bare PATT implies SOUR and SEL
            r_next.leaf  = (k == scc_pkg::KW_PATT) ? scc_pkg::KW_SEL : k;
            r_next.pseen = 1'b0;
            r_next.kw_len = 5'd0;
            r_next.kw_hash = 32'h0;
            r_next.pidx  = 8'h0;
            r_next.st    = term ? scc_pkg::ST_WAIT : scc_pkg::ST_PARM;
          end
          else
          begin
            r_next.kw_hash = hadd(r_reg.kw_hash, c, r_reg.kw_len);
            r_next.kw_len  = (r_reg.kw_len == 5'd31) ? r_reg.kw_len : r_reg.kw_len + 5'd1;
          end
        end
      end
      scc_pkg::ST_PARM:
      begin
        if (r_reg.ch_full)
        begin
          r_next.ch_full = 1'b0;
          if (term)
          begin
            r_next.ptype = pat_dec(r_reg.kw_hash);
            r_next.st    = scc_pkg::ST_WAIT;
            if (r_reg.pseen)
              r_next.leaf = scc_pkg::KW_BAD;
          end
          else if (c == `SCC_CH_BAR)
            r_next.pseen = 1'b1;
          else if (is_digit(c) && r_reg.kw_len != 5'd0)
            r_next.pidx = 8'(r_reg.pidx * 8'd10 + 8'(c - 8'h30));
          else if (c != `SCC_CH_SPACE)
          begin
            r_next.kw_hash = hadd(r_reg.kw_hash, c, r_reg.kw_len);
            r_next.kw_len  = r_reg.kw_len + 5'd1;
          end
        end
      end
      scc_pkg::ST_WAIT:
      begin
        // Hold until sequential work drained and, for wait, overlapped too
        if (!i_seq_busy && !(r_reg.leaf == scc_pkg::KW_WAI && r_reg.pend != 4'h0))
          r_next.st = scc_pkg::ST_EXEC;
      end
      scc_pkg::ST_EXEC:
      begin
        r_next.st = scc_pkg::ST_IDLE;
        if (c == `SCC_CH_LF)
          r_next.path = scc_pkg::KW_NONE;
        case (r_reg.leaf)
          scc_pkg::KW_SEL:
          begin
            if (r_reg.kw_query)
            begin
              r_next.reply = {8'h0, 5'h0, r_reg.pat_type, 8'h0, r_reg.pat_idx};
              r_next.reply_v = 1'b1;
            end
            else if (r_next.ptype == 3'(scc_pkg::PAT_NONE))
              ev[1] = 1'b1;
            else
            begin
              r_next.pat_type = r_reg.ptype;
              r_next.pat_idx  = r_reg.pidx;
              r_next.pat_load = 1'b1;
            end
          end
          scc_pkg::KW_GATE:  begin r_next.start[0] = 1'b1; r_next.pend[0] = 1'b1; end
          scc_pkg::KW_TCEN:  begin r_next.start[1] = 1'b1; r_next.pend[1] = 1'b1; end
          scc_pkg::KW_ACEN:  begin r_next.start[2] = 1'b1; r_next.pend[2] = 1'b1; end
          scc_pkg::KW_ELOC:  begin r_next.start[3] = 1'b1; r_next.pend[3] = 1'b1; end
          scc_pkg::KW_IDN:
          begin
            r_next.reply   = 32'h0000_1d00;
            r_next.reply_v = 1'b1;
          end
          scc_pkg::KW_CLS:
          begin
            r_next.esr      = 8'h00;
            r_next.errq_cnt = 4'h0;
          end
          scc_pkg::KW_WAI, scc_pkg::KW_OPC: ;
          default: ev[0] = 1'b1;
        endcase
        r_next.kw_query = 1'b0;
      end
      default: r_next.st = scc_pkg::ST_IDLE;
    endcase
    if (ev[0])
      esr_set[`SCC_BIT_CME] = 1'b1;
    if (ev[1])
      esr_set[`SCC_BIT_EXE] = 1'b1;
    r_next.esr = r_next.esr | esr_set;
    if (ev[1:0] != 2'b00 && r_reg.errq_cnt != 4'hf)
      r_next.errq_cnt = r_reg.errq_cnt + 4'h1;
    // -----------------------------
    // APB access
    // -----------------------------
    if (wr_acc)
      case (i_paddr)
        `SCC_OFF_CMD:
          if (!r_reg.ch_full)
          begin
            r_next.ch      = i_pwdata[7:0];
            r_next.ch_full = 1'b1;
          end
        `SCC_OFF_ESR:      r_next.esr      = (r_next.esr & ~i_pwdata[7:0]) | esr_set;
        `SCC_OFF_ESE:      begin r_next.ese = i_pwdata[7:0]; r_next.nv_wr = 1'b1; end
        `SCC_OFF_OPER:     begin r_next.oper_ev = (r_next.oper_ev & ~i_pwdata[7:0]) | oper_rise | oper_fall;
                                 r_next.oper_sel = i_pwdata[10:8]; end
        `SCC_OFF_FILT:     begin r_next.filt = i_pwdata[15:0]; r_next.fail_en = i_pwdata[23:16];
                                 r_next.nv_wr = 1'b1; end
        `SCC_OFF_IRQ_ST:   r_next.irq_st   = r_reg.irq_st & ~i_pwdata[3:0];
        `SCC_OFF_IRQ_MASK: r_next.irq_mask = i_pwdata[3:0];
        `SCC_OFF_ERRQ:     r_next.errq_cnt = 4'h0;
        default: ;
      endcase
    if (rd_acc && i_paddr == `SCC_OFF_CMD)
      r_next.reply_v = 1'b0;
    // Sticky interrupt events win over the write clear
    r_next.irq_st = r_next.irq_st | {r_reg.reply_v == 1'b0 && r_next.reply_v,
                                     |(r_next.esr & ~r_reg.esr & r_reg.ese),
                                     |(i_fail & r_reg.fail_en),
                                     r_next.oper_ev[r_reg.oper_sel] & ~r_reg.oper_ev[r_reg.oper_sel]};
    // Read data
    case (i_paddr)
      `SCC_OFF_CMD:      r_next.rdata = r_reg.reply;
      `SCC_OFF_STAT:     r_next.rdata = {20'h0, r_reg.pend, 1'b0, r_reg.st, r_reg.reply_v, 1'b0, ~r_reg.ch_full, o_srq};
      `SCC_OFF_PAT:      r_next.rdata = {21'h0, r_reg.pat_type, r_reg.pat_idx};
      `SCC_OFF_ESR:      r_next.rdata = {24'h0, r_reg.esr};
      `SCC_OFF_ESE:      r_next.rdata = {24'h0, r_reg.ese};
      `SCC_OFF_OPER:     r_next.rdata = {21'h0, r_reg.oper_sel, r_reg.oper_ev};
      `SCC_OFF_FILT:     r_next.rdata = {8'h0, r_reg.fail_en, r_reg.filt};
      `SCC_OFF_IRQ_ST:   r_next.rdata = {28'h0, r_reg.irq_st};
      `SCC_OFF_IRQ_MASK: r_next.rdata = {28'h0, r_reg.irq_mask};
      `SCC_OFF_ERRQ:     r_next.rdata = {28'h0, r_reg.errq_cnt};
      default:           r_next.rdata = 32'h0;
    endcase
  end

  // Registered state, events other than the power-on bit of esr cleared at every power-up
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      r_reg          <= '0;
      r_reg.st       <= scc_pkg::ST_IDLE;
      r_reg.boot     <= 1'b1;
      r_reg.pat_type <= 3'(scc_pkg::PAT_PRBS);
      r_reg.ptype    <= 3'(scc_pkg::PAT_NONE);
    end
    else
      r_reg <= r_next;
  end

  // -----------------------------
  // Outputs
  // -----------------------------
  assign o_prdata    = r_reg.rdata;
  assign o_pready    = i_psel & i_penable;
  assign o_pslverr   = 1'b0;
  assign o_start     = r_reg.start;
  assign o_pat_type  = r_reg.pat_type;
  assign o_pat_index = r_reg.pat_idx;
  assign o_pat_load  = r_reg.pat_load;
  assign o_nv_write  = r_reg.nv_wr;
  assign o_irq       = |(r_reg.irq_st & r_reg.irq_mask);
  assign o_srq       = |(r_reg.esr & r_reg.ese) | |(i_fail & r_reg.fail_en) | r_reg.oper_ev[r_reg.oper_sel];

  // -----------------------------
  // Assertions
  // -----------------------------
  property p_opc_set;
    @(posedge I_CLK) disable iff (!I_RST_N)
      ((r_reg.pend & i_done) != 4'h0) |=> r_reg.esr[`SCC_BIT_OPC];
  endproperty
  a_opc_set: assert property (p_opc_set) else $error("done did not set opc");

  property p_start_pend;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (r_reg.start != 4'h0) |-> ((r_reg.pend & r_reg.start) == r_reg.start);
  endproperty
  a_start_pend: assert property (p_start_pend) else $error("start without pending");

  property p_wai_hold;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (r_reg.st == scc_pkg::ST_WAIT && r_reg.leaf == scc_pkg::KW_WAI && r_reg.pend != 4'h0)
        |=> r_reg.st != scc_pkg::ST_EXEC;
  endproperty
  a_wai_hold: assert property (p_wai_hold) else $error("wait passed pending op");

  property p_seq_hold;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (r_reg.st == scc_pkg::ST_WAIT && i_seq_busy) |=> r_reg.st == scc_pkg::ST_WAIT;
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("executed while busy");

  property p_boot_clear;
    @(posedge I_CLK) disable iff (!I_RST_N)
      r_reg.boot |-> (r_reg.errq_cnt == 4'h0 && r_reg.oper_ev == 8'h00);
  endproperty
  a_boot_clear: assert property (p_boot_clear) else $error("events not clear at power-up");

  property p_virgin;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (r_reg.boot && !i_nv_valid) |=> (r_reg.ese == `SCC_ESE_VIRGIN_X && r_reg.filt == `SCC_FILT_VIRGIN);
  endproperty
  a_virgin: assert property (p_virgin) else $error("virgin defaults wrong");

  property p_keep;
    @(posedge I_CLK) disable iff (!I_RST_N)
      (r_reg.boot && i_nv_valid) |=> (r_reg.ese == $past(i_nv_ese) && r_reg.filt == $past(i_nv_filt));
  endproperty
  a_keep: assert property (p_keep) else $error("enables not restored");

  property p_load;
    @(posedge I_CLK) disable iff (!I_RST_N)
      r_reg.pat_load |-> (r_reg.pat_type == $past(r_reg.ptype) && r_reg.pat_type != 3'(scc_pkg::PAT_NONE));
  endproperty
  a_load: assert property (p_load) else $error("pattern load mismatch");
endmodule

// File: scc_instr_model.sv
// Behavioural model of the pattern generator and detector functions
`timescale 1ns/1ps
module scc_instr_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Requests from the core and the chosen latency
  input  wire logic [3:0] i_start,
  input  wire logic       i_pat_load,
  input  wire logic [2:0] i_pat_type,
  input  wire logic [7:0] i_lat,
  // Answers to the core
  output logic      [3:0] o_done,
  output logic            o_busy
);
  int        cnt [4];
  int        bcnt;
  wire logic upat = i_pat_load && i_pat_type == 3'd3;

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      cnt    <= '{default: 0};
      bcnt   <= 0;
      o_done <= 4'h0;
      o_busy <= 1'b0;
    end
    else
    begin
      // Background operations end after the chosen latency
      for (int k = 0; k < 4; k++)
      begin
        o_done[k] <= cnt[k] == 1;
        cnt[k]    <= i_start[k] ? int'(i_lat) : (cnt[k] > 0 ? cnt[k] - 1 : 0);
      end
      // Lengthy stored pattern load
      bcnt   <= upat ? int'(i_lat) : (bcnt > 0 ? bcnt - 1 : 0);
      o_busy <= upat || bcnt > 1;
    end
endmodule

// File: test_scc_command_status_core.sv
// Self-checking testbench of the command and status core
`timescale 1ns/1ps
`include "scc_defs.svh"
module test_scc_command_status_core;
  // Reply value chosen by the core, arbitrary
  localparam logic [31:0] IDN_REPLY = 32'h0000_1d00;
  logic        I_CLK = 1'b0;
  logic        I_RST_N = 1'b0;
  logic        nv_valid = 1'b0;
  logic [7:0]  nv_ese = 8'h00;
  logic [7:0]  nv_fail = 8'h00;
  logic [15:0] nv_filt = 16'h0000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  fail = 8'h00;
  logic [7:0]  oper = 8'h00;
  logic [7:0]  lat = 8'h28;
  logic [31:0] prdata, r;
  logic [3:0]  start, done;
  logic [3:0]  started = 4'h0;
  logic [2:0]  pat_type;
  logic [7:0]  pat_index;
  logic        pready, pat_load, busy, irq, srq, nv_write;
  logic        nvw = 1'b0;
  int          n_errors = 0, checked = 0, loads = 0, l0, errq = 0;
  time         done_t, load_t;
  string       pc [6] = '{"SOURCE1:PATTERN:SELECT PRBS7", "SOUR1:PATT:SEL ZSUB3", "PATTERN MDENSITY5",
                          "PATT:SEL UPAT2", "SOUR:PATT ZSUBSTITUT4", "PATT:SEL PRBS9;SEL MDEN4"};
  int          et [6] = '{0, 1, 2, 3, 1, 2};
  int          ei [6] = '{7, 3, 5, 2, 4, 4};
  int          nl [6] = '{1, 1, 1, 1, 1, 2};
  string       ov [4] = '{"GATE ON", "EYE:TCEN ONCE", "EYE:ACEN ONCE", "ELOC"};

  always #5 I_CLK = ~I_CLK;

  scc_core uut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .i_nv_valid(nv_valid), .i_nv_ese(nv_ese),
                .i_nv_fail_en(nv_fail), .i_nv_filt(nv_filt), .o_nv_write(nv_write), .i_psel(psel),
                .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
                .o_prdata(prdata), .o_pready(pready), .o_pslverr(), .o_start(start), .i_done(done),
                .o_pat_type(pat_type), .o_pat_index(pat_index), .o_pat_load(pat_load),
                .i_seq_busy(busy), .i_fail(fail), .i_oper_cond(oper), .o_irq(irq), .o_srq(srq));

  scc_instr_model partner (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_start(start), .i_pat_load(pat_load),
                           .i_pat_type(pat_type), .i_lat(lat), .o_done(done), .o_busy(busy));

  always @(posedge I_CLK)
  begin
    started = started | start;
    loads   = loads + pat_load;
    nvw     = nvw | nv_write;
    if (done[0]) done_t = $time;
    if (pat_load) load_t = $time;
  end

  // --------
  // Bus and check tasks
  // --------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge I_CLK);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge I_CLK);
    penable <= 1'b1;
    do @(posedge I_CLK);
    while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task poll(input logic [11:0] a, input int b);
    do apb(1'b0, a, 32'h0, r);
    while (r[b] !== 1'b1);
  endtask

  task idle();
    do apb(1'b0, `SCC_OFF_STAT, 32'h0, r);
    while (r[6:4] !== scc_pkg::ST_IDLE || r[1] !== 1'b1);
  endtask

  task send(input string s);
    for (int i = 0; i <= s.len(); i++)
    begin
      poll(`SCC_OFF_STAT, 1);
      apb(1'b1, `SCC_OFF_CMD, {24'h0, i < s.len() ? s[i] : `SCC_CH_LF}, r);
    end
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task rst(input logic v);
    @(posedge I_CLK);
    I_RST_N  <= 1'b0;
    nv_valid <= v;
    nv_ese   <= 8'($urandom);
    nv_fail  <= 8'($urandom);
    nv_filt  <= 16'($urandom);
    repeat (4) @(posedge I_CLK);
    I_RST_N <= 1'b1;
  endtask

  task finish_test();
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // --------
  // Tests
  // --------
  initial
  begin
    void'($urandom(69051));
    lat = 8'd40 + 8'($urandom % 40);
    rst(1'b0);
    apb(1'b0, `SCC_OFF_ESE, 32'h0, r);
    chk("ese", r, {24'h0, `SCC_ESE_VIRGIN_X});
    apb(1'b0, `SCC_OFF_FILT, 32'h0, r);
    chk("filt", r, {8'h0, `SCC_FAIL_VIRGIN, `SCC_FILT_VIRGIN});
    apb(1'b0, `SCC_OFF_ERRQ, 32'h0, r);
    chk("errq", r, 0);
    @(posedge I_CLK) fail <= 8'h01 << ($urandom % 8);
    apb(1'b0, `SCC_OFF_IRQ_ST, 32'h0, r);
    chk("fail irq", r[1], 1);
    fail <= 8'h00;
    rst(1'b1);
    apb(1'b0, `SCC_OFF_ESE, 32'h0, r);
    chk("ese kept", r, {24'h0, nv_ese});
    apb(1'b0, `SCC_OFF_FILT, 32'h0, r);
    chk("filt kept", r, {8'h0, nv_fail, nv_filt});
    apb(1'b0, `SCC_OFF_ERRQ, 32'h0, r);
    chk("errq", r, 0);
    apb(1'b0, `SCC_OFF_ESR, 32'h0, r);
    chk("esr", r & 32'h31, 0);
    for (int i = 0; i < 6; i++)
    begin
      l0 = loads;
      send(pc[i]);
      idle();
      chk("pattern type", {29'h0, pat_type}, et[i]);
      chk("pattern index", {24'h0, pat_index}, ei[i]);
      chk("loads", loads - l0, nl[i]);
    end
    send("PATT?");
    poll(`SCC_OFF_STAT, 3);
    apb(1'b0, `SCC_OFF_CMD, 32'h0, r);
    chk("pattern reply", r, (et[5] << 16) | ei[5]);
    apb(1'b0, `SCC_OFF_STAT, 32'h0, r);
    chk("reply flag", r[3], 0);
    apb(1'b1, `SCC_OFF_IRQ_ST, 32'hf, r);
    apb(1'b1, `SCC_OFF_IRQ_MASK, 32'h4, r);
    apb(1'b1, `SCC_OFF_ESE, {24'h0, `SCC_ESE_VIRGIN_X}, r);
    send("PATT PRBS1|ZSUB2");
    idle();
    errq++;
    apb(1'b0, `SCC_OFF_ESR, 32'h0, r);
    chk("cmd error", r[`SCC_BIT_CME], 1);
    chk("pattern kept", {29'h0, pat_type}, et[5]);
    apb(1'b0, `SCC_OFF_ERRQ, 32'h0, r);
    chk("errq", r, errq);
    @(negedge I_CLK) chk("irq", irq, 1);
    apb(1'b1, `SCC_OFF_IRQ_MASK, 32'hb, r);
    @(negedge I_CLK) chk("irq masked", irq, 0);
    apb(1'b1, `SCC_OFF_IRQ_MASK, 32'h4, r);
    apb(1'b1, `SCC_OFF_IRQ_ST, 32'h4, r);
    @(negedge I_CLK) chk("irq cleared", irq, 0);
    apb(1'b1, `SCC_OFF_ESR, 32'hff, r);
    for (int k = 0; k < 4; k++)
    begin
      send(ov[k]);
      idle();
      chk("started", started, (1 << (k + 1)) - 1);
      apb(1'b0, `SCC_OFF_STAT, 32'h0, r);
      chk("pending", r[8 + k], 1);
      poll(`SCC_OFF_ESR, `SCC_BIT_OPC);
      apb(1'b0, `SCC_OFF_STAT, 32'h0, r);
      chk("pending done", r[11:8], 0);
      apb(1'b1, `SCC_OFF_ESR, 32'hff, r);
    end
    send("GATE ON");
    send("*WAI");
    send("PATT MDEN6");
    idle();
    chk("wait order", load_t > done_t, 1);
    chk("pattern index", {24'h0, pat_index}, 6);
    send("PATT UPAT3");
    send("*IDN?");
    poll(`SCC_OFF_STAT, 3);
    chk("idn after load", busy, 0);
    apb(1'b0, `SCC_OFF_CMD, 32'h0, r);
    chk("idn", r, IDN_REPLY);
    apb(1'b1, `SCC_OFF_OPER, 32'h3ff, r);
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, `SCC_OFF_FILT, m ? 32'h800 : 32'h8, r);
      @(posedge I_CLK) oper <= 8'h08;
      apb(1'b0, `SCC_OFF_OPER, 32'h0, r);
      chk("rise event", r[3], !m);
      chk("srq rise", srq, !m);
      apb(1'b1, `SCC_OFF_OPER, 32'h3ff, r);
      @(posedge I_CLK) oper <= 8'h00;
      apb(1'b0, `SCC_OFF_OPER, 32'h0, r);
      chk("fall event", r[3], m);
      chk("srq fall", srq, m);
      apb(1'b1, `SCC_OFF_OPER, 32'h3ff, r);
    end
    chk("nv save", nvw, 1);
    finish_test();
  end

  // Far beyond the expected run of a few thousand cycles
  initial
  begin
    #500us;
    n_errors++;
    finish_test();
  end
endmodule
